// File: verif/bringup_assertions.sv
// checker for the bring-up controller: power-down pin timing, flags
// assumes binding into serializer_bringup with its count parameters
`timescale 1ns/1ps
module bringup_assertions #(
    parameter int T2_CYC = 10000,
    parameter int T3_CYC = 30000,
    parameter int T4_CYC = 20000
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic supplyStable,
    input wire logic sclOe,
    input wire logic sdaOe,
    input wire logic powerDownN,
    input wire logic busy,
    input wire logic done,
    input wire logic failed,
    input wire logic [2:0] tempCode
);
    int upCnt;
    int loCnt;
    int sinceRst;
    always_ff @(posedge clk) begin
        if (srst) begin
            upCnt <= 0;
            loCnt <= 0;
            sinceRst <= 0;
        end else begin
            upCnt <= powerDownN ? upCnt + 1 : 0;
            loCnt <= (busy && !powerDownN) ? loCnt + 1 : 0;
            sinceRst <= (sinceRst < 8) ? sinceRst + 1 : sinceRst;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_reset_state: assert property (disable iff (1'b0) srst |=>
        !powerDownN && !busy && !done && !failed && tempCode == 3'h0)
        else $error("outputs not cleared by reset");
    a_start_powerup: assert property (!busy && start && supplyStable &&
        $past(supplyStable, 4) && sinceRst == 8 |=> busy && powerDownN)
        else $error("accepted start did not raise the pin");
    a_hold_high: assert property ($fell(powerDownN) && busy |->
        upCnt >= T2_CYC) else $error("pin high too short before pulse");
    a_low_pulse: assert property ($rose(powerDownN) && loCnt != 0 |->
        loCnt >= T3_CYC) else $error("power-down pulse too short");
    a_i2c_wait: assert property (sclOe || sdaOe |->
        powerDownN && upCnt >= T4_CYC) else $error("bus used too early");
    a_busy_rise: assert property ($rose(busy) |->
        $past(start) && !done && !failed)
        else $error("run began without start or kept old flags");
    a_end_flags: assert property ($fell(busy) |-> done != failed)
        else $error("run ended without exactly one flag");
    a_flags_excl: assert property (!(done && failed))
        else $error("done and failed together");
    a_temp_hold: assert property (!busy |=> $stable(tempCode))
        else $error("temperature code moved while idle");
    cover property ($fell(powerDownN) && busy);
    cover property ($rose(done));
    cover property ($rose(failed));
endmodule // bringup_assertions

// File: verif/i2c_device_model.sv
// behavioural serializer and deserializer sharing one i2c bus
// assumes the bench resolves open-drain wires with pull-ups
`timescale 1ns/1ps
module i2c_device_model
    import bringup_pkg::*;
#(
    parameter logic [6:0] DES_ADDR = 7'h30,
    parameter logic [6:0] SER_ADDR = 7'h18
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic nackSer,
    input wire logic powerDownN,
    output logic sdaOe
);
    logic [7:0] desMem [256];
    logic [7:0] serMem [256];
    logic [7:0] anaMem [256];
    logic [16:0] wrLog [$];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [7:0] rb;
    logic act, isSer, rdMode, addrPh, gotReg, nak, locked;
    int cnt;
    int softResets;
    initial begin
        sdaOe = 0;
        act = 0;
        cnt = 0;
        softResets = 0;
    end
    // analog registers sit behind the page 0x04 window
    function automatic logic [7:0] rdByte();
        if (!isSer) return desMem[ptr];
        if (ptr == INDIRECT_DATA &&
            serMem[INDIRECT_PAGE_SELECT] == ANALOG_PAGE)
            return anaMem[serMem[INDIRECT_ADDRESS]];
        return serMem[ptr];
    endfunction
    task automatic wrByte(input logic [7:0] d);
        wrLog.push_back({isSer, ptr, d});
        if (!isSer) desMem[ptr] = d;
        else if (ptr == INDIRECT_DATA && serMem[INDIRECT_PAGE_SELECT] ==
            ANALOG_PAGE) anaMem[serMem[INDIRECT_ADDRESS]] = d;
        else serMem[ptr] = d;
        // soft reset applies settings, lock regained on back channel
        if (isSer && ptr == SOFT_RESET_CONTROL && d[0]) begin
            softResets++;
            locked = 1;
        end
        ptr++;
    endtask
    // hs receiver and its termination sit on the data path, not here
    // powered down: the part lets go of the bus
    always @(negedge powerDownN) begin
        act = 0;
        sdaOe = 0;
    end
    always @(negedge sda) if (scl) begin
        act = 1;
        cnt = 0;
        addrPh = 1;
        rdMode = 0;
        gotReg = 0;
    end
    always @(posedge sda) if (scl) act = 0;
    always @(posedge scl) if (act) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        else nak = sda;
        cnt++;
    end
    always @(negedge scl) if (act) begin
        if (cnt == 8) begin
            if (rdMode) sdaOe = 0;
            else if (addrPh) begin
                isSer = (sh[7:1] == SER_ADDR);
                if ((isSer && !nackSer) || sh[7:1] == DES_ADDR) begin
                    sdaOe = 1;
                    rdMode = sh[0];
                    addrPh = 0;
                end else act = 0;
            end else begin
                sdaOe = 1;
                if (gotReg) wrByte(sh);
                else ptr = sh;
                gotReg = 1;
            end
        end else if (cnt == 9) begin
            cnt = 0;
            // one assignment per edge so sda never glitches
            if (rdMode && !nak) begin
                rb = rdByte();
                ptr++;
                sdaOe = ~rb[7];
            end else begin
                sdaOe = 0;
                if (rdMode) act = 0;
            end
        end else if (rdMode && cnt > 0) sdaOe = ~rb[7 - cnt];
    end
endmodule // i2c_device_model

// File: verif/tb.sv
// random bring-up runs of the controller against the device model
// assumes shortened power-down counts and pull-ups on both bus wires
`timescale 1ns/1ps
`define CHK(what, want, got) begin \
    n_compared++; \
    if ((got) !== (want)) begin \
        err_count++; \
        $display("[ERR] %s exp %0h got %0h", what, want, got); \
    end \
end
module tb;
    localparam int T2 = 20;
    localparam int T3 = 30;
    localparam int T4 = 20;
    logic clk, srst, linkClk, start, hardReset, supplyStable, nackSer;
    logic sclOe, sdaOe, devOe, powerDownN, busy, done, failed;
    logic [2:0] tempCode;
    logic [31:0] lfsr;
    int err_count;
    int n_compared;
    wire sclW = ~sclOe;
    wire sdaW = ~(sdaOe | devOe);
    serializer_bringup #(.T2_CYC(T2), .T3_CYC(T3), .T4_CYC(T4)) DUT (
        .clk(clk), .srst(srst), .linkClk(linkClk), .start(start),
        .hardReset(hardReset), .supplyStable(supplyStable), .sclIn(sclW),
        .sdaIn(sdaW), .sclOut(), .sclOe(sclOe), .sdaOut(), .sdaOe(sdaOe),
        .powerDownN(powerDownN), .busy(busy), .done(done),
        .failed(failed), .tempCode(tempCode));
    i2c_device_model dev (.scl(sclW), .sda(sdaW), .nackSer(nackSer),
        .powerDownN(powerDownN), .sdaOe(devOe));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    initial begin
        linkClk = 0;
        #7;
        forever #15 linkClk = ~linkClk;
    end
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // offset per temperature code, two's complement
    function automatic logic [7:0] tempOffset(input logic [2:0] c);
        case (c)
            3'h0, 3'h1: return 8'hff;
            3'h2, 3'h3: return 8'h00;
            3'h7: return 8'h03;
            default: return 8'h01;
        endcase
    endfunction
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // filter needs the supply high a few edges after release
    task automatic resetDut();
        @(negedge clk);
        srst = 1;
        repeat (6) @(negedge clk);
        srst = 0;
        repeat (5) @(negedge clk);
    endtask
    task automatic run(input logic [2:0] code, input logic hr, input logic nk);
        logic [7:0] r58, dyn, fix;
        logic [16:0] want [10];
        int i;
        lfsr = nextRand(lfsr);
        {fix, dyn, r58} = lfsr[23:0];
        dev.desMem[8'h58] = r58;
        dev.desMem[8'h53] = {lfsr[28:24], code};
        dev.anaMem[8'h4b] = dyn;
        dev.anaMem[8'h4c] = fix;
        dev.wrLog.delete();
        dev.softResets = 0;
        want = '{{1'b0, 8'h58, r58 | 8'h40}, {1'b1, 8'h0a, 8'h12},
            {1'b1, 8'hb0, 8'h04}, {1'b1, 8'hb1, 8'h4b}, {1'b1, 8'hb1, 8'h4c},
            {1'b1, 8'hb2, (fix & 8'h8f) | 8'h70}, {1'b1, 8'hb1, 8'h4b},
            {1'b1, 8'hb2, (dyn | 8'h20) + tempOffset(code)},
            {1'b0, 8'h58, r58 | 8'h60}, {1'b1, 8'h01, 8'h01}};
        @(negedge clk);
        start = 1;
        hardReset = hr;
        nackSer = nk;
        @(negedge clk);
        start = 0;
        // a second start mid-run must be ignored
        repeat (60) @(negedge clk);
        start = 1;
        @(negedge clk);
        start = 0;
        for (i = 0; i < 20000 && !(done || failed); i++) @(negedge clk);
        if (nk) begin
            `CHK("failed", 1'b1, failed)
            `CHK("writes", 32'd1, 32'(dev.wrLog.size()))
        end else begin
            `CHK("done", 1'b1, done)
            `CHK("soft resets", 1, dev.softResets)
            `CHK("temp code", code, tempCode)
            `CHK("writes", 32'd10, 32'(dev.wrLog.size()))
            for (i = 0; i < 10; i++)
                `CHK("write", want[i], dev.wrLog[i])
        end
        $display("run code %0d hard %0d nack %0d ended", code, hr, nk);
    endtask
    initial begin
        int c;
        srst = 1;
        start = 0;
        hardReset = 0;
        supplyStable = 0;
        nackSer = 0;
        err_count = 0;
        n_compared = 0;
        lfsr = 32'h809b915d;
        resetDut();
        // start refused while the supply is not yet stable
        start = 1;
        repeat (8) @(negedge clk);
        start = 0;
        `CHK("pin, supply low", 1'b0, powerDownN)
        `CHK("busy, supply low", 1'b0, busy)
        supplyStable = 1;
        repeat (5) @(negedge clk);
        for (c = 0; c < 8; c++) run(3'(c), c[0], 1'b0);
        lfsr = nextRand(lfsr);
        run(lfsr[2:0], 1'b0, 1'b1);
        run(lfsr[5:3], 1'b1, 1'b0);
        @(negedge clk);
        start = 1;
        @(negedge clk);
        start = 0;
        repeat (200) @(negedge clk);
        resetDut();
        `CHK("pin after reset", 1'b0, powerDownN)
        `CHK("busy after reset", 1'b0, busy)
        run(lfsr[8:6], 1'b1, 1'b0);
        finish_test();
    end
    initial begin
        #4000000;
        err_count++;
        $display("watchdog expired");
        finish_test();
    end
endmodule // tb
bind serializer_bringup bringup_assertions #(.T2_CYC(T2_CYC),
    .T3_CYC(T3_CYC), .T4_CYC(T4_CYC)) chk (.clk(clk), .srst(srst),
    .start(start), .supplyStable(supplyStable), .sclOe(sclOe),
    .sdaOe(sdaOe), .powerDownN(powerDownN), .busy(busy), .done(done),
    .failed(failed), .tempCode(tempCode));

// File: verilog/bringup_pkg.sv
// constants, carriers and states for the serializer bring-up controller
// assumes a 10 MHz system clock and a deserializer reached over i2c
// How it works
// - power_down_n_input may rise at once when the main supply is stable.
// - a hard reset holds power_down_n_input high 1 ms before pulling it low.
// - the hard reset low pulse lasts 3 ms, then 2 ms pass before any i2c.
// - watchdog speed-up 0x0a gets 0x12 before remote serializer access.
// - fixed thermal-slope bits 6:4 of analog 0x4c become 0x7, rest kept.
// - adjustable thermal slope at analog 0x4b is read value plus offset.
// - temp codes 0-1 give -1, 2-3 give 0, 4-6 give 1, 7 gives 3.
// - the 3-bit temperature code comes from deserializer register 0x53.
// - bit 5 of the adjustable setting is set before the offset is added.
// - 0x01 written to register 0x01 soft-resets the serializer last.
// - deserializer 0x58 gets 0x40 before, and 0x20 added after, tuning.
package bringup_pkg;
    localparam logic [7:0] SOFT_RESET_CONTROL = 8'h01;
    localparam logic [7:0] I2C_WATCHDOG_SPEEDUP = 8'h0a;
    localparam logic [7:0] THERMAL_SLOPE_ADJUSTABLE = 8'h4b;
    localparam logic [7:0] THERMAL_SLOPE_FIXED = 8'h4c;
    localparam logic [7:0] INDIRECT_PAGE_SELECT = 8'hb0;
    localparam logic [7:0] INDIRECT_ADDRESS = 8'hb1;
    localparam logic [7:0] INDIRECT_DATA = 8'hb2;
    localparam logic [7:0] DES_PASSTHROUGH_CTRL = 8'h58;
    localparam logic [7:0] REMOTE_TEMPERATURE_STATUS = 8'h53;
    localparam logic [7:0] WATCHDOG_FAST = 8'h12;
    localparam logic [7:0] ANALOG_PAGE = 8'h04;
    localparam logic [7:0] PASSTHROUGH_EN = 8'h40;
    localparam logic [7:0] AUTO_ACK_EN = 8'h20;
    localparam logic [7:0] FIXED_KEEP_MASK = 8'h8f;
    localparam logic [7:0] FIXED_SLOPE_VAL = 8'h70;
    localparam logic [7:0] OVERRIDE_BIT = 8'h20;
    localparam logic [7:0] SOFT_RESET_VAL = 8'h01;
    localparam logic [7:0] OFFSET_MINUS1 = 8'hff;
    localparam logic [7:0] OFFSET_ZERO = 8'h00;
    localparam logic [7:0] OFFSET_PLUS1 = 8'h01;
    localparam logic [7:0] OFFSET_PLUS3 = 8'h03;
    localparam int CLK_KHZ = 10000;
    localparam int T2_MS = 1;
    localparam int T3_MS = 3;
    localparam int T4_MS = 2;
    localparam int T2_CYCLES = T2_MS * CLK_KHZ;
    localparam int T3_CYCLES = T3_MS * CLK_KHZ;
    localparam int T4_CYCLES = T4_MS * CLK_KHZ;
    localparam logic [3:0] STEP_RD_58 = 4'h0;
    localparam logic [3:0] STEP_RD_TEMP = 4'h3;
    localparam logic [3:0] STEP_RD_DYN = 4'h6;
    localparam logic [3:0] STEP_RD_FIX = 4'h8;
    localparam logic [3:0] STEP_LAST = 4'hd;

    typedef struct packed {
        logic rd;
        logic [6:0] dev;
        logic [7:0] regAddr;
        logic [7:0] data;
    } i2c_req_t;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_HOLD_HI = 3'b001,
        M_PULSE_LO = 3'b010,
        M_WAIT_RDY = 3'b011,
        M_ISSUE = 3'b100,
        M_WAIT = 3'b101
    } main_state_t;

    typedef enum logic [2:0] {
        L_IDLE = 3'b000,
        L_START = 3'b001,
        L_TX = 3'b010,
        L_RX = 3'b011,
        L_STOP = 3'b100
    } link_state_t;
endpackage

// File: verilog/serializer_bringup.sv
// host-side bring-up sequencer: power-down pin timing, then the register
// script over an i2c master clocked by linkClk (scl = linkClk / 8)
// assumes open-drain pins resolved outside and pull-ups on scl and sda
`timescale 1ns/1ps
module serializer_bringup
    import bringup_pkg::*;
#(
    parameter int T2_CYC = T2_CYCLES,
    parameter int T3_CYC = T3_CYCLES,
    parameter int T4_CYC = T4_CYCLES,
    parameter logic [6:0] DES_ADDR = 7'h30,
    parameter logic [6:0] SER_ADDR = 7'h18
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic linkClk,
    input wire logic start,
    input wire logic hardReset,
    input wire logic supplyStable,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe,
    output logic powerDownN,
    output logic busy,
    output logic done,
    output logic failed,
    output logic [2:0] tempCode
);
    // arbitrary default device addresses, set per board
    if (T2_CYC < 1 || T2_CYC > 65536 || T3_CYC < 1 || T3_CYC > 65536 ||
        T4_CYC < 1 || T4_CYC > 65536) begin : g_bad_count
        $error("bring-up counts must lie in 1..65536");
    end

    typedef struct packed {
        main_state_t st;
        logic [15:0] cnt;
        logic [3:0] step;
        i2c_req_t req;
        logic reqTgl;
        logic dnS1;
        logic dnS2;
        logic dnS3;
        logic dnSeen;
        logic supS1;
        logic supS2;
        logic supS3;
        logic supLvl;
        logic [7:0] r58;
        logic [2:0] temp;
        logic [7:0] dyn;
        logic [7:0] fix;
        logic pdn;
        logic busy;
        logic done;
        logic failed;
    } main_t;

    typedef struct packed {
        link_state_t st;
        logic rstS1;
        logic rstS2;
        logic rstS3;
        logic rqS1;
        logic rqS2;
        logic rqS3;
        logic rqSeen;
        i2c_req_t req;
        logic [2:0] ph;
        logic [3:0] bitCnt;
        logic [1:0] byteIdx;
        logic [7:0] sh;
        logic [7:0] rdata;
        logic nack;
        logic doneTgl;
        logic sdaS1;
        logic sdaS2;
        logic sdaS3;
        logic sdaLvl;
        logic sclLow;
        logic sdaLow;
    } link_t;

    main_t m;
    main_t next_m;
    link_t l;
    link_t next_l;

    function automatic logic [7:0] tempOffset(input logic [2:0] code);
        unique case (code)
            3'h0, 3'h1: tempOffset = OFFSET_MINUS1;
            3'h2, 3'h3: tempOffset = OFFSET_ZERO;
            3'h4, 3'h5, 3'h6: tempOffset = OFFSET_PLUS1;
            3'h7: tempOffset = OFFSET_PLUS3;
        endcase
    endfunction

    function automatic i2c_req_t opOf(input main_t s);
        opOf = '{rd: 1'b0, dev: SER_ADDR, regAddr: 8'h00, data: 8'h00};
        unique case (s.step)
            4'h0: opOf = '{1'b1, DES_ADDR, DES_PASSTHROUGH_CTRL, 8'h00};
            4'h1: opOf = '{1'b0, DES_ADDR, DES_PASSTHROUGH_CTRL,
                           s.r58 | PASSTHROUGH_EN};
            4'h2: opOf = '{1'b0, SER_ADDR, I2C_WATCHDOG_SPEEDUP,
                           WATCHDOG_FAST};
            4'h3: opOf = '{1'b1, DES_ADDR, REMOTE_TEMPERATURE_STATUS, 8'h00};
            4'h4: opOf = '{1'b0, SER_ADDR, INDIRECT_PAGE_SELECT, ANALOG_PAGE};
            4'h5: opOf = '{1'b0, SER_ADDR, INDIRECT_ADDRESS,
                           THERMAL_SLOPE_ADJUSTABLE};
            4'h6: opOf = '{1'b1, SER_ADDR, INDIRECT_DATA, 8'h00};
            4'h7: opOf = '{1'b0, SER_ADDR, INDIRECT_ADDRESS,
                           THERMAL_SLOPE_FIXED};
            4'h8: opOf = '{1'b1, SER_ADDR, INDIRECT_DATA, 8'h00};
            // fixed slope bits 6:4, rest kept
            4'h9: opOf = '{1'b0, SER_ADDR, INDIRECT_DATA,
                           (s.fix & FIXED_KEEP_MASK) | FIXED_SLOPE_VAL};
            4'ha: opOf = '{1'b0, SER_ADDR, INDIRECT_ADDRESS,
                           THERMAL_SLOPE_ADJUSTABLE};
            4'hb: opOf = '{1'b0, SER_ADDR, INDIRECT_DATA,
                           (s.dyn | OVERRIDE_BIT) + tempOffset(s.temp)};
            4'hc: opOf = '{1'b0, DES_ADDR, DES_PASSTHROUGH_CTRL,
                           s.r58 | PASSTHROUGH_EN | AUTO_ACK_EN};
            4'hd: opOf = '{1'b0, SER_ADDR, SOFT_RESET_CONTROL,
                           SOFT_RESET_VAL};
            default: opOf = '{1'b0, SER_ADDR, SOFT_RESET_CONTROL,
                              SOFT_RESET_VAL};
        endcase
    endfunction

    // system clock domain: pin timing and script
    always_comb begin
        next_m = m;
        next_m.supS1 = supplyStable;
        next_m.supS2 = m.supS1;
        next_m.supS3 = m.supS2;
        if (m.supS2 == m.supS3) begin
            next_m.supLvl = m.supS3;
        end
        next_m.dnS1 = l.doneTgl;
        next_m.dnS2 = m.dnS1;
        next_m.dnS3 = m.dnS2;
        unique case (m.st)
            M_IDLE: begin
                // raise at once on stable supply
                if (start && m.supLvl) begin
                    next_m.pdn = 1'b1;
                    next_m.busy = 1'b1;
                    next_m.done = 1'b0;
                    next_m.failed = 1'b0;
                    if (hardReset) begin
                        next_m.st = M_HOLD_HI;
                        next_m.cnt = 16'(T2_CYC - 1);
                    end else begin
                        next_m.st = M_WAIT_RDY;
                        next_m.cnt = 16'(T4_CYC - 1);
                    end
                end
            end
            M_HOLD_HI: begin
                next_m.cnt = m.cnt - 16'h0001;
                if (m.cnt == 16'h0000) begin
                    next_m.pdn = 1'b0;
                    next_m.st = M_PULSE_LO;
                    next_m.cnt = 16'(T3_CYC - 1);
                end
            end
            M_PULSE_LO: begin
                next_m.cnt = m.cnt - 16'h0001;
                if (m.cnt == 16'h0000) begin
                    next_m.pdn = 1'b1;
                    next_m.st = M_WAIT_RDY;
                    next_m.cnt = 16'(T4_CYC - 1);
                end
            end
            M_WAIT_RDY: begin
                next_m.cnt = m.cnt - 16'h0001;
                if (m.cnt == 16'h0000) begin
                    next_m.st = M_ISSUE;
                    next_m.step = 4'h0;
                end
            end
            M_ISSUE: begin
                // request held stable until the done toggle returns
                next_m.req = opOf(m);
                next_m.reqTgl = ~m.reqTgl;
                next_m.st = M_WAIT;
            end
            M_WAIT: begin
                if (m.dnS2 == m.dnS3 && m.dnS3 != m.dnSeen) begin
                    next_m.dnSeen = m.dnS3;
                    // link result words are stable after the toggle
                    if (l.nack) begin
                        next_m.failed = 1'b1;
                        next_m.busy = 1'b0;
                        next_m.st = M_IDLE;
                    end else begin
                        if (m.step == STEP_RD_58) begin
                            next_m.r58 = l.rdata;
                        end
                        if (m.step == STEP_RD_TEMP) begin
                            next_m.temp = l.rdata[2:0];
                        end
                        if (m.step == STEP_RD_DYN) begin
                            next_m.dyn = l.rdata;
                        end
                        if (m.step == STEP_RD_FIX) begin
                            next_m.fix = l.rdata;
                        end
                        if (m.step == STEP_LAST) begin
                            next_m.done = 1'b1;
                            next_m.busy = 1'b0;
                            next_m.st = M_IDLE;
                        end else begin
                            next_m.step = m.step + 4'h1;
                            next_m.st = M_ISSUE;
                        end
                    end
                end
            end
            default: next_m.st = M_IDLE;
        endcase
        if (srst) begin
            next_m = '0;
            next_m.st = M_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        m <= next_m;
    end

    // link domain: byte-level i2c master, 8 link clocks per bit
    always_comb begin
        next_l = l;
        next_l.rstS1 = srst;
        next_l.rstS2 = l.rstS1;
        next_l.rstS3 = l.rstS2;
        next_l.rqS1 = m.reqTgl;
        next_l.rqS2 = l.rqS1;
        next_l.rqS3 = l.rqS2;
        next_l.sdaS1 = sdaIn;
        next_l.sdaS2 = l.sdaS1;
        next_l.sdaS3 = l.sdaS2;
        if (l.sdaS2 == l.sdaS3) begin
            next_l.sdaLvl = l.sdaS3;
        end
        next_l.ph = l.ph + 3'h1;
        next_l.sclLow = 1'b0;
        next_l.sdaLow = 1'b0;
        unique case (l.st)
            L_IDLE: begin
                next_l.ph = 3'h0;
                if (l.rqS2 == l.rqS3 && l.rqS3 != l.rqSeen) begin
                    next_l.rqSeen = l.rqS3;
                    next_l.req = m.req;
                    next_l.nack = 1'b0;
                    next_l.byteIdx = 2'h0;
                    next_l.st = L_START;
                end
            end
            L_START: begin
                next_l.sclLow = l.ph < 3'h2 || l.ph >= 3'h6;
                next_l.sdaLow = l.ph >= 3'h4;
                if (l.ph == 3'h7) begin
                    next_l.st = L_TX;
                    next_l.bitCnt = 4'h0;
                    next_l.sh = (l.byteIdx == 2'h0) ? {l.req.dev, 1'b0} :
                                {l.req.dev, 1'b1};
                end
            end
            L_TX: begin
                next_l.sclLow = l.ph < 3'h2 || l.ph >= 3'h6;
                next_l.sdaLow = (l.bitCnt < 4'h8) && !l.sh[7];
                if (l.ph == 3'h6 && l.bitCnt == 4'h8) begin
                    next_l.nack = l.sdaLvl;
                end
                if (l.ph == 3'h7) begin
                    if (l.bitCnt < 4'h8) begin
                        next_l.sh = {l.sh[6:0], 1'b0};
                        next_l.bitCnt = l.bitCnt + 4'h1;
                    end else if (l.nack) begin
                        next_l.st = L_STOP;
                    end else begin
                        next_l.byteIdx = l.byteIdx + 2'h1;
                        next_l.bitCnt = 4'h0;
                        if (l.byteIdx == 2'h0) begin
                            next_l.sh = l.req.regAddr;
                        end else if (l.byteIdx == 2'h1) begin
                            // reads turn round with a repeated start
                            if (l.req.rd) begin
                                next_l.st = L_START;
                            end else begin
                                next_l.sh = l.req.data;
                            end
                        end else begin
                            next_l.st = l.req.rd ? L_RX : L_STOP;
                        end
                    end
                end
            end
            L_RX: begin
                // master leaves sda released, ninth bit is the nack
                next_l.sclLow = l.ph < 3'h2 || l.ph >= 3'h6;
                if (l.ph == 3'h6 && l.bitCnt < 4'h8) begin
                    next_l.sh = {l.sh[6:0], l.sdaLvl};
                end
                if (l.ph == 3'h7) begin
                    if (l.bitCnt == 4'h8) begin
                        next_l.rdata = l.sh;
                        next_l.st = L_STOP;
                    end else begin
                        next_l.bitCnt = l.bitCnt + 4'h1;
                    end
                end
            end
            L_STOP: begin
                next_l.sclLow = l.ph < 3'h2;
                next_l.sdaLow = l.ph < 3'h6;
                if (l.ph == 3'h7) begin
                    next_l.doneTgl = ~l.doneTgl;
                    next_l.st = L_IDLE;
                end
            end
            default: next_l.st = L_IDLE;
        endcase
        // reset arrives through the same three-stage agreement
        if (l.rstS2 && l.rstS3) begin
            next_l = '0;
            next_l.st = L_IDLE;
            next_l.rstS1 = srst;
            next_l.rstS2 = l.rstS1;
            next_l.rstS3 = l.rstS2;
        end
    end

    always_ff @(posedge linkClk) begin
        l <= next_l;
    end

    // open-drain pins: only ever pull low
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = l.sclLow;
    assign sdaOe = l.sdaLow;
    assign powerDownN = m.pdn;
    assign busy = m.busy;
    assign done = m.done;
    assign failed = m.failed;
    assign tempCode = m.temp;

    // clock stretching is not honoured; sclIn is left for the bench
    logic sclSeen;
    assign sclSeen = sclIn;
endmodule // serializer_bringup
